// ---- edge_time_stamp.sv ----
// Two-channel edge time stamp block with records and input area
//////////////////////////////////////////////////////////////////////////////////////////////
// How it works
// R1 - Small variant shows twenty input bytes, at most five entries.
// R2 - Large variant shows sixty input bytes, at most fifteen entries.
// R3 - Input length reads 14h or 3Ch per variant; writes refused.
// R4 - Output length always reads zero; no output data used.
// R5 - Filter codes select 2 to 2731 us; default 02h; others rejected.
// R6 - Rise select byte bits 0 and 1 enable capture per channel.
// R7 - Fall select byte bits 0 and 1 enable capture; both default zero.
// R8 - Each enabled edge records ticker value and both input states.
// R9 - New entry lands at offset 0; older entries move up four bytes.
// R10 - When full, inserting drops the oldest entry for good.
// R11 - Host sends length record only while the system is stopped.
// R12 - No interrupts; diagnostic record is read-only information.
// R13 - Short diagnostic record returns only the first four bytes.
// R14 - Module information byte reads class 1111b plus info flag.
// R15 - Channel kind byte reads 70h, bit 7 zero.
// R16 - Diagnostic bits per channel byte reads zero.
// R17 - Partner must supply the microsecond ticker value.
// R18 - Diagnostic stamp holds ticker captured when diagnostics were generated.
// R19 - Channel count byte reads two.
// R20 - Edges are detected on the filtered inputs.
// R21 - Simultaneous edges insert one entry each, channel 0 first.
module edge_time_stamp #(
    parameter bit          LARGE_VARIANT = 1'b0,
    parameter int unsigned CYC_86        = ets_pkg::CYC_86US,
    parameter int unsigned CYC_342       = ets_pkg::CYC_342US,
    parameter int unsigned CYC_2731      = ets_pkg::CYC_2731US
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic [1:0]  I_DIN,
    input  wire logic [31:0] I_US_TICKER,
    input  wire logic        I_REC_WR,
    input  wire logic        I_REC_RD,
    input  wire logic [7:0]  I_REC_SET,
    input  wire logic [7:0]  I_REC_IDX,
    input  wire logic [7:0]  I_REC_WDATA,
    input  wire logic [5:0]  I_AREA_IDX,
    output logic      [7:0]  O_REC_RDATA,
    output logic             O_REC_ERR,
    output logic      [7:0]  O_AREA_DATA,
    output logic      [1:0]  O_DIN_FILT
);

    // Variant sets depth and length
    localparam int unsigned DEPTH = LARGE_VARIANT ? ets_pkg::ENTRIES_MAX
                                                  : ets_pkg::ENTRIES_SMALL;
    localparam logic [7:0]  IN_LEN = LARGE_VARIANT ? ets_pkg::IN_LEN_LARGE
                                                   : ets_pkg::IN_LEN_SMALL;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Input filters

    filt_if                 fif [ets_pkg::NUM_CH] ();
    logic [7:0]             code_q [ets_pkg::NUM_CH];
    logic [7:0]             code_d [ets_pkg::NUM_CH];
    logic [1:0]             filt;
    logic [1:0]             filt_prev_q;

    // One filter per channel, fed by its own delay code
    for (genvar c = 0; c < ets_pkg::NUM_CH; c++) begin : g_ch
        assign fif[c].raw  = I_DIN[c];
        assign fif[c].code = code_q[c];
        assign filt[c]     = fif[c].filt;
        input_delay_filter #(
            .CYC_86   (CYC_86),
            .CYC_342  (CYC_342),
            .CYC_2731 (CYC_2731)
        ) u_filt (
            .I_CLK (I_CLK),
            .I_RST (I_RST),
            .port  (fif[c])
        );
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Parameter state

    logic [1:0]             rise_en_q, rise_en_d;
    logic [1:0]             fall_en_q, fall_en_d;
    logic                   rec_err_d, rec_err_q;
    logic                   code_ok;

    // Only the six listed delay codes are accepted
    always_comb begin
        case (I_REC_WDATA)
            ets_pkg::CODE_2US,
            ets_pkg::CODE_4US,
            ets_pkg::CODE_12US,
            ets_pkg::CODE_86US,
            ets_pkg::CODE_342US,
            ets_pkg::CODE_2731US: code_ok = 1'b1; // [R5]
            default: code_ok = 1'b0;
        endcase
    end

    // Record writes; length record writes are refused since both lengths are fixed
    always_comb begin
        code_d    = code_q;
        rise_en_d = rise_en_q;
        fall_en_d = fall_en_q;
        rec_err_d = 1'b0;
        if (I_REC_WR) begin
            if (I_REC_SET == ets_pkg::SET_CHAN && I_REC_IDX < 8'(ets_pkg::NUM_CH)) begin
                if (code_ok) begin
                    code_d[I_REC_IDX[0]] = I_REC_WDATA; // [R5]
                end else begin
                    rec_err_d = 1'b1; // [R5]
                end
            end else if (I_REC_SET == ets_pkg::SET_EDGE && I_REC_IDX == ets_pkg::IDX_FIRST) begin
                rise_en_d = I_REC_WDATA[1:0]; // [R6]
            end else if (I_REC_SET == ets_pkg::SET_EDGE && I_REC_IDX == ets_pkg::IDX_SECOND) begin
                fall_en_d = I_REC_WDATA[1:0]; // [R7]
            end else begin
                rec_err_d = 1'b1; // [R3] [R4]
            end
        end
    end

    // Parameter registers
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            code_q    <= '{default: ets_pkg::CODE_DEFAULT}; // [R5]
            rise_en_q <= ets_pkg::EDGE_MASK_RST; // [R7]
            fall_en_q <= ets_pkg::EDGE_MASK_RST; // [R7]
            rec_err_q <= 1'b0;
        end else begin
            code_q    <= code_d;
            rise_en_q <= rise_en_d;
            fall_en_q <= fall_en_d;
            rec_err_q <= rec_err_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Edge capture and entry shift buffer

    logic [31:0]            ent_q [ets_pkg::ENTRIES_MAX];
    logic [31:0]            ent_d [ets_pkg::ENTRIES_MAX];
    logic [3:0]             count_q, count_d;
    logic [7:0]             seq_q, seq_d;
    logic [1:0]             hit;
    logic [31:0]            new0, new1;
    logic [4:0]             sum2;

    // Edges come from the filtered levels so glitches never stamp
    always_comb begin
        for (int c = 0; c < ets_pkg::NUM_CH; c++) begin
            hit[c] = (rise_en_q[c] & filt[c] & ~filt_prev_q[c])     // [R20] [R6]
                   | (fall_en_q[c] & ~filt[c] & filt_prev_q[c]);    // [R20] [R7]
        end
    end

    // Entry: input states, sequence number, low half of the ticker
    assign new0 = {I_US_TICKER[15:0], seq_q, 6'h00, filt};          // [R8]
    assign new1 = {I_US_TICKER[15:0], seq_q + 8'h01, 6'h00, filt};  // [R8]
    // Widened so the large buffer count cannot wrap
    assign sum2 = {1'b0, count_q} + 5'h02;

    // Insert at the front; the tail falls off when full, one slot per entry
    always_comb begin
        ent_d   = ent_q;
        count_d = count_q;
        seq_d   = seq_q;
        case (hit)
            2'b01, 2'b10: begin
                ent_d[0] = new0; // [R9]
                for (int i = 1; i < ets_pkg::ENTRIES_MAX; i++) begin
                    ent_d[i] = ent_q[i-1]; // [R9] [R10]
                end
                count_d = (count_q >= 4'(DEPTH)) ? 4'(DEPTH) : count_q + 4'h1; // [R10]
                seq_d   = seq_q + 8'h01;
            end
            2'b11: begin
                // Channel 0 first: one slot deeper
                ent_d[0] = new1; // [R21]
                ent_d[1] = new0; // [R21]
                for (int i = 2; i < ets_pkg::ENTRIES_MAX; i++) begin
                    ent_d[i] = ent_q[i-2]; // [R9] [R10]
                end
                count_d = (sum2 >= 5'(DEPTH)) ? 4'(DEPTH) : sum2[3:0]; // [R10]
                seq_d   = seq_q + 8'h02;
            end
            default: begin
                ent_d = ent_q;
            end
        endcase
    end

    // Buffer registers
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            ent_q       <= '{default: 32'h0000_0000};
            count_q     <= 4'h0;
            seq_q       <= 8'h00;
            filt_prev_q <= 2'h0;
        end else begin
            ent_q       <= ent_d;
            count_q     <= count_d;
            seq_q       <= seq_d;
            filt_prev_q <= filt;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Input area read port

    logic [7:0]             area_d, area_q;
    logic [3:0]             slot;

    // Four bytes per entry
    assign slot = 4'(I_AREA_IDX >> 2);

    // Bytes past the variant length or of empty slots read zero
    always_comb begin
        area_d = 8'h00;
        if (8'(I_AREA_IDX) < IN_LEN && slot < count_q) begin // [R1] [R2] [R10]
            case (I_AREA_IDX[1:0])
                ets_pkg::ENT_STATE: area_d = ent_q[slot][7:0];
                ets_pkg::ENT_SEQ:   area_d = ent_q[slot][15:8];
                ets_pkg::ENT_US_LO: area_d = ent_q[slot][23:16];
                default:            area_d = ent_q[slot][31:24];
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Record read port

    logic [7:0]             rd_d, rd_q;
    logic [31:0]            stamp_q, stamp_d;
    logic                   diag_gen;

    // Diagnostics are generated when the first byte of either diag record is read
    assign diag_gen = I_REC_RD && I_REC_IDX == ets_pkg::IDX_FIRST &&
                      (I_REC_SET == ets_pkg::SET_CHAN ||
                       I_REC_SET == ets_pkg::SET_DIAG_SHORT);
    assign stamp_d  = diag_gen ? I_US_TICKER : stamp_q; // [R18]

    // Set 01h reads as diagnostics; writes to it carry filter codes instead
    always_comb begin
        rd_d = rd_q;
        if (I_REC_RD) begin
            rd_d = ets_pkg::DIAG_RSVD;
            case (I_REC_SET)
                ets_pkg::SET_LEN: begin
                    if (I_REC_IDX == ets_pkg::IDX_FIRST) begin
                        rd_d = IN_LEN; // [R3]
                    end else begin
                        rd_d = ets_pkg::OUT_LEN; // [R4]
                    end
                end
                ets_pkg::SET_EDGE: begin
                    if (I_REC_IDX == ets_pkg::IDX_FIRST) begin
                        rd_d = {6'h00, rise_en_q}; // [R6]
                    end else begin
                        rd_d = {6'h00, fall_en_q}; // [R7]
                    end
                end
                ets_pkg::SET_CHAN, ets_pkg::SET_DIAG_SHORT: begin
                    if (I_REC_SET == ets_pkg::SET_DIAG_SHORT &&
                        I_REC_IDX >= ets_pkg::DIAG_SHORT_LEN) begin
                        rd_d = ets_pkg::DIAG_RSVD; // [R13]
                    end else if (I_REC_IDX == ets_pkg::DIAG_IDX_CLASS) begin
                        rd_d = ets_pkg::DIAG_MODULE_CLASS; // [R14]
                    end else if (I_REC_IDX == ets_pkg::DIAG_IDX_KIND) begin
                        rd_d = ets_pkg::DIAG_CHAN_KIND; // [R15]
                    end else if (I_REC_IDX == ets_pkg::DIAG_IDX_BITS) begin
                        rd_d = ets_pkg::DIAG_BITS_PER_CH; // [R16]
                    end else if (I_REC_IDX == ets_pkg::DIAG_IDX_CHANS) begin
                        rd_d = ets_pkg::DIAG_NUM_CH; // [R19]
                    end else if (I_REC_IDX >= ets_pkg::DIAG_IDX_STAMP &&
                                 I_REC_IDX < ets_pkg::DIAG_LEN) begin
                        rd_d = stamp_q[8*I_REC_IDX[1:0] +: 8]; // [R18]
                    end
                end
                default: rd_d = ets_pkg::DIAG_RSVD;
            endcase
        end
    end

    // Output registers
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rd_q    <= 8'h00;
            area_q  <= 8'h00;
            stamp_q <= 32'h0000_0000;
        end else begin
            rd_q    <= rd_d;
            area_q  <= area_d;
            stamp_q <= stamp_d;
        end
    end

    // No interrupt output exists; diagnostics are reached only by reading
    assign O_REC_RDATA = rd_q;      // [R12]
    assign O_REC_ERR   = rec_err_q;
    assign O_AREA_DATA = area_q;
    assign O_DIN_FILT  = filt;

endmodule : edge_time_stamp

// ---- ets_pkg.sv ----
// Constants shared by the two-channel edge time stamp block
package ets_pkg;
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned NUM_CH        = 2;
    localparam int unsigned ENTRIES_SMALL = 5;
    localparam int unsigned ENTRIES_MAX   = 15;
    localparam int unsigned ENTRY_BYTES   = 4;
    localparam int unsigned CNT_W         = 20;
    localparam int unsigned AREA_IDX_W    = 6;

    // Parameter record layout
    localparam logic [7:0] SET_DIAG_SHORT = 8'h00;
    localparam logic [7:0] SET_CHAN       = 8'h01;
    localparam logic [7:0] SET_LEN        = 8'h02;
    localparam logic [7:0] SET_EDGE       = 8'h80;
    localparam logic [7:0] IDX_FIRST      = 8'h00;
    localparam logic [7:0] IDX_SECOND     = 8'h01;

    // Fixed lengths and edge select reset values
    localparam logic [7:0] IN_LEN_SMALL   = 8'h14;
    localparam logic [7:0] IN_LEN_LARGE   = 8'h3C;
    localparam logic [7:0] OUT_LEN        = 8'h00;
    localparam logic [7:0] EDGE_RESET     = 8'h00;
    localparam logic [1:0] EDGE_MASK_RST  = 2'h0;

    // Filter codes and times
    localparam logic [7:0] CODE_2US       = 8'h00;
    localparam logic [7:0] CODE_4US       = 8'h02;
    localparam logic [7:0] CODE_12US      = 8'h04;
    localparam logic [7:0] CODE_86US      = 8'h07;
    localparam logic [7:0] CODE_342US     = 8'h09;
    localparam logic [7:0] CODE_2731US    = 8'h0C;
    localparam logic [7:0] CODE_DEFAULT   = CODE_4US;
    localparam int unsigned T_2US         = 2;
    localparam int unsigned T_4US         = 4;
    localparam int unsigned T_12US        = 12;
    localparam int unsigned T_86US        = 86;
    localparam int unsigned T_342US       = 342;
    localparam int unsigned T_2731US      = 2731;
    localparam int unsigned CYC_2US       = T_2US * CLK_MHZ;
    localparam int unsigned CYC_4US       = T_4US * CLK_MHZ;
    localparam int unsigned CYC_12US      = T_12US * CLK_MHZ;
    localparam int unsigned CYC_86US      = T_86US * CLK_MHZ;
    localparam int unsigned CYC_342US     = T_342US * CLK_MHZ;
    localparam int unsigned CYC_2731US    = T_2731US * CLK_MHZ;

    // Diagnostic record layout
    localparam logic [7:0] DIAG_MODULE_CLASS = 8'h1F;
    localparam logic [7:0] DIAG_CHAN_KIND    = 8'h70;
    localparam logic [7:0] DIAG_BITS_PER_CH  = 8'h00;
    localparam logic [7:0] DIAG_NUM_CH       = 8'h02;
    localparam logic [7:0] DIAG_RSVD         = 8'h00;
    localparam logic [7:0] DIAG_IDX_CLASS    = 8'h01;
    localparam logic [7:0] DIAG_IDX_KIND     = 8'h04;
    localparam logic [7:0] DIAG_IDX_BITS     = 8'h05;
    localparam logic [7:0] DIAG_IDX_CHANS    = 8'h06;
    localparam logic [7:0] DIAG_IDX_STAMP    = 8'h10;
    localparam logic [7:0] DIAG_SHORT_LEN    = 8'h04;
    localparam logic [7:0] DIAG_LEN          = 8'h14;

    // Entry byte positions
    localparam logic [1:0] ENT_STATE  = 2'h0;
    localparam logic [1:0] ENT_SEQ    = 2'h1;
    localparam logic [1:0] ENT_US_LO  = 2'h2;
endpackage : ets_pkg

// ---- filt_if.sv ----
// Carrier between the top and one input delay filter
interface filt_if;
    logic       raw;
    logic [7:0] code;
    logic       filt;
    modport ctrl (output raw, output code, input filt);
    modport filter (input raw, input code, output filt);
endinterface : filt_if

// ---- input_delay_filter.sv ----
// Input delay filter for one channel
module input_delay_filter #(
    parameter int unsigned CYC_86    = ets_pkg::CYC_86US,
    parameter int unsigned CYC_342   = ets_pkg::CYC_342US,
    parameter int unsigned CYC_2731  = ets_pkg::CYC_2731US
) (
    input  wire logic I_CLK,
    input  wire logic I_RST,
    filt_if.filter    port
);
    logic [ets_pkg::CNT_W-1:0] cnt_q, cnt_d, limit;
    logic                      filt_q, filt_d;

    // Code to hold time; an unknown code falls back to the default time
    always_comb begin
        case (port.code)
            ets_pkg::CODE_2US:    limit = ets_pkg::CNT_W'(ets_pkg::CYC_2US);
            ets_pkg::CODE_12US:   limit = ets_pkg::CNT_W'(ets_pkg::CYC_12US);
            ets_pkg::CODE_86US:   limit = ets_pkg::CNT_W'(CYC_86);
            ets_pkg::CODE_342US:  limit = ets_pkg::CNT_W'(CYC_342);
            ets_pkg::CODE_2731US: limit = ets_pkg::CNT_W'(CYC_2731);
            default:              limit = ets_pkg::CNT_W'(ets_pkg::CYC_4US);
        endcase
    end

    // A level must stand for the full hold time before it passes; glitches restart it
    always_comb begin
        cnt_d  = '0;
        filt_d = filt_q;
        if (port.raw != filt_q) begin
            if (cnt_q + 1'b1 >= limit) begin
                filt_d = port.raw;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            cnt_q  <= '0;
            filt_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            filt_q <= filt_d;
        end
    end

    assign port.filt = filt_q;
endmodule : input_delay_filter

// ---- ticker_model.sv ----
// Partner model: the head module's free-running microsecond ticker
module ticker_model #(
    parameter int unsigned DIV   = 200,
    parameter logic [31:0] START = 32'h00A5_C3F0
) (
    input  wire logic        i_clk,
    output logic      [31:0] o_us
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned div_cnt = 0;
    logic [31:0] us_q = START;
    assign o_us = us_q;
    // Counts on regardless of the block's reset, as a head module would
    always @(posedge i_clk) begin
        if (div_cnt == DIV - 1) begin
            div_cnt <= 0;
            us_q    <= us_q + 32'h0000_0001;
        end else begin
            div_cnt <= div_cnt + 1;
        end
    end
endmodule : ticker_model

// ---- stamp_checker.sv ----
// Port-level assertions for the edge time stamp block
module stamp_checker #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic [1:0]  I_DIN,
    input wire logic [31:0] I_US_TICKER,
    input wire logic        I_REC_WR,
    input wire logic        I_REC_RD,
    input wire logic [7:0]  I_REC_SET,
    input wire logic [7:0]  I_REC_IDX,
    input wire logic [7:0]  I_REC_WDATA,
    input wire logic [5:0]  I_AREA_IDX,
    input wire logic [7:0]  O_REC_RDATA,
    input wire logic        O_REC_ERR,
    input wire logic [7:0]  O_AREA_DATA,
    input wire logic [1:0]  O_DIN_FILT
);
    localparam logic [7:0] EXP_LEN = LARGE_VARIANT ? 8'h3C : 8'h14;
    logic good_code;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // Only these delay codes may be accepted
    assign good_code = I_REC_WDATA inside {8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0C};
    sequence rec_read_s(logic [7:0] s, logic [7:0] i);
        I_REC_RD && I_REC_SET == s && I_REC_IDX == i;
    endsequence
    sequence rec_write_s(logic [7:0] s);
        I_REC_WR && I_REC_SET == s;
    endsequence
    property read_gives_p(logic [7:0] s, logic [7:0] i, logic [7:0] v);
        rec_read_s(s, i) |=> O_REC_RDATA == v;
    endproperty
    in_len_a: assert property (read_gives_p(8'h02, 8'h00, EXP_LEN))
        else $error("input length byte wrong");
    out_len_a: assert property (read_gives_p(8'h02, 8'h01, 8'h00))
        else $error("output length byte wrong");
    class_info_a: assert property (read_gives_p(8'h01, 8'h01, 8'h1F))
        else $error("module class byte wrong");
    chan_kind_a: assert property (read_gives_p(8'h01, 8'h04, 8'h70))
        else $error("channel kind byte wrong");
    diag_bits_a: assert property (read_gives_p(8'h01, 8'h05, 8'h00))
        else $error("diagnostic bit count wrong");
    chan_count_a: assert property (read_gives_p(8'h01, 8'h06, 8'h02))
        else $error("channel count wrong");
    short_diag_a: assert property (I_REC_RD && I_REC_SET == 8'h00 && I_REC_IDX >= 8'h04
        |=> O_REC_RDATA == 8'h00)
        else $error("short record too long");
    fixed_len_a: assert property (rec_write_s(8'h02) |=> O_REC_ERR)
        else $error("length write not refused");
    bad_code_a: assert property (rec_write_s(8'h01) ##0 (I_REC_IDX < 8'h02 && !good_code)
        |=> O_REC_ERR)
        else $error("bad delay code not refused");
    good_code_a: assert property (rec_write_s(8'h01) ##0 (I_REC_IDX < 8'h02 && good_code)
        |=> !O_REC_ERR)
        else $error("valid delay code refused");
    area_end_a: assert property ({2'h0, I_AREA_IDX} >= EXP_LEN |=> O_AREA_DATA == 8'h00)
        else $error("byte past input area not zero");
    state_rsvd_a: assert property (I_AREA_IDX[1:0] == 2'h0 |=> O_AREA_DATA[7:2] == 6'h00)
        else $error("state byte upper bits set");
endmodule : stamp_checker

bind edge_time_stamp stamp_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_stamp_chk (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_DIN(I_DIN), .I_US_TICKER(I_US_TICKER),
    .I_REC_WR(I_REC_WR), .I_REC_RD(I_REC_RD), .I_REC_SET(I_REC_SET), .I_REC_IDX(I_REC_IDX),
    .I_REC_WDATA(I_REC_WDATA), .I_AREA_IDX(I_AREA_IDX), .O_REC_RDATA(O_REC_RDATA),
    .O_REC_ERR(O_REC_ERR), .O_AREA_DATA(O_AREA_DATA), .O_DIN_FILT(O_DIN_FILT));

// ---- tb.sv ----
// Self-checking bench for the edge time stamp block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  din = 2'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  set = 8'h00;
    logic [7:0]  idx = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [5:0]  aidx = 6'h00;
    logic [31:0] tick;
    logic [7:0]  rdata;
    logic        err;
    logic [7:0]  adata;
    logic [1:0]  filt;
    logic [7:0]  v;
    logic [31:0] stamp;
    logic [23:0] hist[$];
    int          error_cnt = 0;
    int          compares = 0;
    int          cycles = 0;
    ticker_model u_tick (.i_clk(clk), .o_us(tick));
    // Short filter counts keep the slow codes affordable
    edge_time_stamp #(.LARGE_VARIANT(1'b0), .CYC_86(20), .CYC_342(40), .CYC_2731(60)) dut (
        .I_CLK(clk), .I_RST(rst), .I_DIN(din), .I_US_TICKER(tick), .I_REC_WR(wr),
        .I_REC_RD(rd), .I_REC_SET(set), .I_REC_IDX(idx), .I_REC_WDATA(wdata),
        .I_AREA_IDX(aidx), .O_REC_RDATA(rdata), .O_REC_ERR(err), .O_AREA_DATA(adata),
        .O_DIN_FILT(filt));
    initial forever #2.5 clk = ~clk;
    // Hang guard, well above the roughly 10k cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic test_done();
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One record byte; v gets the read byte or the refusal flag
    task automatic acc(input logic w, input logic [7:0] s, i, d);
        @(negedge clk);
        set = s;
        idx = i;
        wdata = d;
        wr = w;
        rd = !w;
        stamp = tick;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        v = w ? {7'h00, err} : rdata;
    endtask : acc
    task automatic area(input logic [5:0] a);
        @(negedge clk);
        aidx = a;
        @(negedge clk);
        v = adata;
    endtask : area
    // Bounded wait for the filtered level; stamp is the ticker of that cycle
    task automatic move(input logic [1:0] d);
        @(negedge clk);
        din = d;
        for (int k = 0; k < 3000 && filt !== d; k++) @(negedge clk);
        check("filtered level", filt, d);
        stamp = tick;
    endtask : move
    // Compares the whole input area, newest entry first, one slot past the end
    task automatic slots();
        logic [7:0] e;
        for (int k = 0; k < 6; k++) begin
            for (int b = 0; b < 4; b++) begin
                area(6'(4 * k + b));
                e = 8'h00;
                if (k < 5 && k < hist.size()) begin
                    case (b)
                        0: e = hist[k][23:16];
                        1: e = 8'(hist.size() - 1 - k);
                        2: e = hist[k][7:0];
                        default: e = hist[k][15:8];
                    endcase
                end
                check("area byte", v, e);
            end
        end
    endtask : slots
    task automatic filt_time(input int ch, input logic [7:0] code, input int n);
        logic [1:0] want;
        if (code !== 8'h02) acc(1'b1, 8'h01, ch[7:0], code);
        want = filt ^ (2'h1 << ch);
        @(negedge clk);
        din = want;
        repeat (n - 1) @(negedge clk);
        check("filter early", filt, want ^ (2'h1 << ch));
        @(negedge clk);
        check("filter delay", filt, want);
    endtask : filt_time
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        acc(1'b0, 8'h02, 8'h00, 8'h00);
        check("input length", v, 8'h14);
        acc(1'b0, 8'h02, 8'h01, 8'h00);
        check("output length", v, 8'h00);
        acc(1'b0, 8'h80, 8'h00, 8'h00);
        check("rise select", v, 8'h00);
        acc(1'b0, 8'h80, 8'h01, 8'h00);
        check("fall select", v, 8'h00);
    endtask : t_reset
    task automatic t_diag();
        logic [7:0]  e;
        logic [31:0] st;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 20; i++) begin
                acc(1'b0, 8'(1 - s), 8'(i), 8'h00);
                if (i == 0) st = stamp;
                case (i)
                    1: e = 8'h1F;
                    4: e = 8'h70;
                    6: e = 8'h02;
                    16, 17, 18, 19: e = st[8 * (i - 16) +: 8];
                    default: e = 8'h00;
                endcase
                if (s == 1 && i >= 4) e = 8'h00;
                check("diag byte", v, e);
            end
        end
    endtask : t_diag
    // Every delay code timed; no edge selected, so the area stays empty
    task automatic t_filter();
        filt_time(0, 8'h02, 800);
        filt_time(1, 8'h07, 20);
        filt_time(1, 8'h09, 40);
        filt_time(1, 8'h0C, 60);
        filt_time(0, 8'h04, 2400);
        filt_time(0, 8'h00, 400);
        slots();
    endtask : t_filter
    task automatic t_writes();
        logic [7:0] bad[5] = '{8'h01, 8'h03, 8'h05, 8'h0D, 8'hFF};
        logic [7:0] good[6] = '{8'h02, 8'h04, 8'h07, 8'h09, 8'h0C, 8'h00};
        for (int c = 0; c < 2; c++) begin
            foreach (bad[k]) begin
                acc(1'b1, 8'h01, 8'(c), bad[k]);
                check("bad code refused", v, 8'h01);
            end
            foreach (good[k]) begin
                acc(1'b1, 8'h01, 8'(c), good[k]);
                check("code taken", v, 8'h00);
            end
        end
        acc(1'b1, 8'h02, 8'h00, 8'h3C);
        check("length write refused", v, 8'h01);
        acc(1'b0, 8'h02, 8'h00, 8'h00);
        check("length kept", v, 8'h14);
        for (int i = 0; i < 2; i++) begin
            acc(1'b1, 8'h80, 8'(i), 8'hFF);
            acc(1'b0, 8'h80, 8'(i), 8'h00);
            check("select reserved bits", v, 8'h03);
        end
    endtask : t_writes
    // Rise on ch0, fall on ch1; six entries overflow the five slots
    task automatic t_capture();
        logic [1:0] pat[4] = '{2'b01, 2'b00, 2'b01, 2'b11};
        acc(1'b1, 8'h80, 8'h00, 8'h01);
        acc(1'b1, 8'h80, 8'h01, 8'h02);
        for (int r = 0; r < 12; r++) begin
            move(pat[r % 4]);
            if (r % 2 == 0) hist.push_front({6'h00, pat[r % 4], stamp[15:0]});
            slots();
        end
    endtask : t_capture
    task automatic t_simul();
        acc(1'b1, 8'h80, 8'h00, 8'h03);
        acc(1'b1, 8'h80, 8'h01, 8'h00);
        move(2'b00);
        move(2'b11);
        hist.push_front({8'h03, stamp[15:0]});
        hist.push_front({8'h03, stamp[15:0]});
        slots();
    endtask : t_simul
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_diag();
        t_filter();
        t_writes();
        t_capture();
        t_simul();
        test_done();
    end
endmodule : tb
